// *** include/pbm_pkg.sv ***
package pbm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_OPTIONS = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_MEAS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_BAL_DELTA = 8'h14;
    localparam logic [7:0] OFS_EOC_THR = 8'h18;
    localparam logic [7:0] OFS_TEMP_LIM = 8'h1c;
    localparam logic [7:0] OFS_TEMP_REC = 8'h20;
    // option bits
    localparam int OPT_FET_TEMP = 0;
    localparam int OPT_CELL_FAULT_FLAG_PSD = 1;
    localparam int OPT_OW_PSD = 2;
    localparam int OPT_SUPPLY_LOW_LOCKOUT_PD = 3;
    localparam int OPT_OW_SCAN_DIS = 4;
    localparam int OPT_BAL_LSB = 5;
    localparam int OPT_W = 7;
    // measurement control fields
    localparam int MEAS_START = 4;
    localparam int MEAS_BUSY = 5;
    localparam int MEAS_GAIN_LSB = 6;
    localparam int RES_VALID = 15;
    // status bits
    localparam int ST_PSD = 0;
    localparam int ST_BAL_EN = 1;
    localparam int ST_FET_OFF = 2;
    localparam int ST_FORCED = 3;
    localparam int ST_MODE_LSB = 4;
    // reset values
    localparam logic [6:0] RST_OPTIONS = 7'h00;
    localparam logic [13:0] RST_BAL_DELTA = 14'h0010;
    localparam logic [13:0] RST_EOC_THR = 14'h3fff;
    localparam logic [13:0] RST_TEMP_LIM = 14'h0000;
    localparam logic [13:0] RST_TEMP_REC = 14'h0000;
    localparam logic [1:0] RST_GAIN = 2'h0;
    // end-of-charge release band
    localparam int EOC_HYST_MV = 117;
    // balance mode selection
    localparam logic [1:0] BAL_CHARGE = 2'h0;
    localparam logic [1:0] BAL_DISCHARGE = 2'h1;
    localparam logic [1:0] BAL_EOC = 2'h2;
    // forced mode request codes, also the operating state codes
    typedef enum logic [2:0] {
        PBM_NORMAL = 3'h0,
        PBM_IDLE = 3'h1,
        PBM_DOZE = 3'h2,
        PBM_SLEEP = 3'h3,
        PBM_PDOWN = 3'h4
    } pbm_mode_t;
endpackage

// *** hw/pbm_ctrl.sv ***
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module pbm_ctrl #(
    parameter int NCELL = 8,
    parameter int ADC_LSB_UV = 1000
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    // asynchronous status pins
    input wire logic CHG_DET,
    input wire logic DSG_DET,
    input wire logic CELL_FAULT,
    input wire logic OPEN_WIRE,
    input wire logic SUPPLY_LOW,
    // same-clock measurement values
    input wire logic [NCELL*14-1:0] CELL_V,
    input wire logic [13:0] TEMP1_CODE,
    input wire logic [13:0] TEMP2_CODE,
    // converter
    output logic ADC_START,
    output logic [3:0] ADC_CHAN,
    output logic [1:0] ADC_GAIN,
    input wire logic ADC_DONE,
    input wire logic [13:0] ADC_DATA,
    // pack control
    output logic PACK_SHUTDOWN,
    output logic POWER_DOWN,
    output logic POWER_FET_OFF,
    output logic SCAN_EN,
    output logic OW_SCAN_EN,
    output logic [NCELL-1:0] CB_OUT,
    output logic [2:0] OP_MODE
);

    localparam int HYST_CODE = (pbm_pkg::EOC_HYST_MV * 1000) / ADC_LSB_UV;
    localparam logic [13:0] HYST = HYST_CODE[13:0];

    // refuse cell counts the 4-bit channel field cannot reach
    if (NCELL < 1 || NCELL > 16 || ADC_LSB_UV < 1 || HYST_CODE > 16383) begin : g_bad_params
        $error("pbm_ctrl: unsupported parameters");
    end

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [6:0] opt;
        pbm_pkg::pbm_mode_t st;
        logic forced;
        logic [13:0] bal_delta;
        logic [13:0] eoc_thr;
        logic [13:0] t_lim;
        logic [13:0] t_rec;
        logic ot1;
        logic ot2;
        logic eoc_act;
        logic bal_en;
        logic [3:0] chan;
        logic [1:0] gain;
        logic busy;
        logic [13:0] res;
        logic res_vld;
        logic pack_shutdown;
        logic [NCELL-1:0] cb;
        logic fet_off;
        logic ow_en;
        logic adc_start;
        logic pd;
        logic scan;
        logic [31:0] hrdata;
        logic a_wr;
        logic [7:0] a_addr;
    } pbm_state_t;

    localparam pbm_state_t RST_STATE = '{
        s1: 5'h00,
        s2: 5'h00,
        opt: pbm_pkg::RST_OPTIONS,
        st: pbm_pkg::PBM_NORMAL,
        forced: 1'b0,
        bal_delta: pbm_pkg::RST_BAL_DELTA,
        eoc_thr: pbm_pkg::RST_EOC_THR,
        t_lim: pbm_pkg::RST_TEMP_LIM,
        t_rec: pbm_pkg::RST_TEMP_REC,
        ot1: 1'b0,
        ot2: 1'b0,
        eoc_act: 1'b0,
        bal_en: 1'b0,
        chan: 4'h0,
        gain: pbm_pkg::RST_GAIN,
        busy: 1'b0,
        res: 14'h0000,
        res_vld: 1'b0,
        pack_shutdown: 1'b0,
        cb: '0,
        fet_off: 1'b0,
        ow_en: 1'b0,
        adc_start: 1'b0,
        pd: 1'b0,
        scan: 1'b1,
        hrdata: 32'h0000_0000,
        a_wr: 1'b0,
        a_addr: 8'h00
    };

    pbm_state_t s_q;
    pbm_state_t s_d;

    function automatic logic [13:0] cell_at(input logic [NCELL*14-1:0] v, input int i);
        cell_at = v[i*14 +: 14];
    endfunction

    // true when any cell is strictly above thr, or at/above when ge is set
    function automatic logic any_above(input logic [NCELL*14-1:0] v,
                                       input logic [13:0] thr, input logic ge);
        logic r;
        r = 1'b0;
        for (int i = 0; i < NCELL; i++) begin
            if (cell_at(v, i) > thr || (ge && cell_at(v, i) == thr)) begin
                r = 1'b1;
            end
        end
        any_above = r;
    endfunction

    function automatic logic [13:0] lowest(input logic [NCELL*14-1:0] v);
        logic [13:0] m;
        m = cell_at(v, 0);
        for (int i = 1; i < NCELL; i++) begin
            if (cell_at(v, i) < m) begin
                m = cell_at(v, i);
            end
        end
        lowest = m;
    endfunction

    function automatic logic [31:0] read_mux(input pbm_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            pbm_pkg::OFS_OPTIONS: r[6:0] = s.opt;
            pbm_pkg::OFS_MODE: r[2:0] = s.st;
            pbm_pkg::OFS_MEAS: r[7:0] = {s.gain, s.busy, 1'b0, s.chan};
            pbm_pkg::OFS_RESULT: r[15:0] = {s.res_vld, 1'b0, s.res};
            pbm_pkg::OFS_STATUS: r[6:0] = {s.st, s.forced, s.fet_off, s.bal_en, s.pack_shutdown};
            pbm_pkg::OFS_BAL_DELTA: r[13:0] = s.bal_delta;
            pbm_pkg::OFS_EOC_THR: r[13:0] = s.eoc_thr;
            pbm_pkg::OFS_TEMP_LIM: r[13:0] = s.t_lim;
            pbm_pkg::OFS_TEMP_REC: r[13:0] = s.t_rec;
            default: r = 32'h0000_0000;
        endcase
        read_mux = r;
    endfunction

    logic chg;
    logic dsg;
    logic cell_fault_flag;
    logic ow;
    logic supply_low_lockout;
    logic [13:0] vmin;
    logic [14:0] bal_thr;
    logic [13:0] eoc_rel;
    logic wr;
    logic [31:0] wd;
    logic cond_ok;
    logic cur_ok;
    logic [1:0] bmode;

    assign chg = s_q.s2[0];
    assign dsg = s_q.s2[1];
    assign cell_fault_flag = s_q.s2[2];
    assign ow = s_q.s2[3];
    assign supply_low_lockout = s_q.s2[4];
    assign vmin = lowest(CELL_V);
    assign bal_thr = {1'b0, vmin} + {1'b0, s_q.bal_delta};
    assign eoc_rel = (s_q.eoc_thr > HYST) ? s_q.eoc_thr - HYST : 14'h0000;
    assign wr = s_q.a_wr;
    assign wd = HWDATA;
    assign bmode = s_q.opt[pbm_pkg::OPT_BAL_LSB +: 2];

    always_comb begin
        s_d = s_q;
        // pins cross through two flops before use
        s_d.s1 = {SUPPLY_LOW, OPEN_WIRE, CELL_FAULT, DSG_DET, CHG_DET};
        s_d.s2 = s_q.s1;
        s_d.adc_start = 1'b0;

        // address phase capture; zero wait states, reads prepared here
        s_d.a_wr = 1'b0;
        if (HSEL && HREADY && HTRANS[1]) begin
            s_d.a_wr = HWRITE;
            s_d.a_addr = HADDR[7:0];
            s_d.hrdata = HWRITE ? 32'h0000_0000 : read_mux(s_q, HADDR[7:0]);
        end

        // temperature codes fall as temperature rises; recovery needs a higher code
        // temp1 and temp2 converted compares
        if (TEMP1_CODE < s_q.t_lim) begin
            s_d.ot1 = 1'b1;
        end else if (TEMP1_CODE > s_q.t_rec) begin
            s_d.ot1 = 1'b0;
        end
        if (TEMP2_CODE < s_q.t_lim) begin
            s_d.ot2 = 1'b1;
        end else if (TEMP2_CODE > s_q.t_rec) begin
            s_d.ot2 = 1'b0;
        end
        s_d.fet_off = s_q.ot1 || s_q.ot2;

        cond_ok = !cell_fault_flag && !s_q.ot1 && !(s_q.ot2 && !s_q.opt[pbm_pkg::OPT_FET_TEMP]);

        if (any_above(CELL_V, s_q.eoc_thr, 1'b1)) begin
            s_d.eoc_act = 1'b1;
        end else if (!any_above(CELL_V, eoc_rel, 1'b0)) begin
            s_d.eoc_act = 1'b0;
        end

        unique case (bmode)
            pbm_pkg::BAL_CHARGE: cur_ok = chg && !dsg;
            pbm_pkg::BAL_DISCHARGE: cur_ok = dsg && !chg;
            pbm_pkg::BAL_EOC: cur_ok = s_q.eoc_act;
            default: cur_ok = 1'b0;
        endcase
        s_d.bal_en = cur_ok && cond_ok;

        for (int i = 0; i < NCELL; i++) begin
            s_d.cb[i] = s_q.bal_en && ({1'b0, cell_at(CELL_V, i)} > bal_thr);
        end

        if (cell_fault_flag && s_q.opt[pbm_pkg::OPT_CELL_FAULT_FLAG_PSD]) begin
            s_d.pack_shutdown = 1'b1;
        end
        if (ow && s_q.opt[pbm_pkg::OPT_OW_PSD]) begin
            s_d.pack_shutdown = 1'b1;
        end

        s_d.ow_en = cell_fault_flag && !s_q.opt[pbm_pkg::OPT_OW_SCAN_DIS];

        if (s_q.busy && ADC_DONE) begin
            s_d.busy = 1'b0;
            s_d.res = ADC_DATA;
            s_d.res_vld = 1'b1;
        end

        // register writes in the data phase
        if (wr) begin
            unique case (s_q.a_addr)
                pbm_pkg::OFS_OPTIONS: s_d.opt = wd[6:0];
                pbm_pkg::OFS_MODE: begin
                    if (s_q.st != pbm_pkg::PBM_PDOWN) begin
                        unique case (wd[2:0])
                            3'h1: s_d.st = pbm_pkg::PBM_IDLE;
                            3'h2: s_d.st = pbm_pkg::PBM_DOZE;
                            3'h3: s_d.st = pbm_pkg::PBM_SLEEP;
                            3'h4: s_d.st = pbm_pkg::PBM_PDOWN;
                            default: s_d.st = s_q.st;
                        endcase
                        s_d.forced = (wd[2:0] >= 3'h1) && (wd[2:0] <= 3'h4);
                    end
                end
                pbm_pkg::OFS_MEAS: begin
                    // start launches conversion with latched gain
                    if (wd[pbm_pkg::MEAS_START] && !s_q.busy) begin
                        s_d.chan = wd[3:0];
                        s_d.gain = wd[pbm_pkg::MEAS_GAIN_LSB +: 2];
                        s_d.busy = 1'b1;
                        s_d.res_vld = 1'b0;
                        s_d.adc_start = 1'b1;
                    end else if (!s_q.busy) begin
                        // selection only; a start while busy is dropped, host polls busy
                        s_d.chan = wd[3:0];
                        s_d.gain = wd[pbm_pkg::MEAS_GAIN_LSB +: 2];
                    end
                end
                pbm_pkg::OFS_STATUS: begin
                    // set beats a same-cycle clear
                    // write one clears; a live fault sets it again
                    if (wd[pbm_pkg::ST_PSD] && !(cell_fault_flag && s_q.opt[pbm_pkg::OPT_CELL_FAULT_FLAG_PSD])
                        && !(ow && s_q.opt[pbm_pkg::OPT_OW_PSD])) begin
                        s_d.pack_shutdown = 1'b0;
                    end
                end
                pbm_pkg::OFS_BAL_DELTA: s_d.bal_delta = wd[13:0];
                pbm_pkg::OFS_EOC_THR: s_d.eoc_thr = wd[13:0];
                pbm_pkg::OFS_TEMP_LIM: s_d.t_lim = wd[13:0];
                pbm_pkg::OFS_TEMP_REC: s_d.t_rec = wd[13:0];
                default: s_d.opt = s_q.opt;
            endcase
        end

        if ((chg || dsg) && s_q.st != pbm_pkg::PBM_PDOWN) begin
            s_d.st = pbm_pkg::PBM_NORMAL;
            s_d.forced = 1'b0;
        end
        if (supply_low_lockout && s_q.opt[pbm_pkg::OPT_SUPPLY_LOW_LOCKOUT_PD]) begin
            s_d.st = pbm_pkg::PBM_PDOWN;
        end
        // decoded ahead of the flop so the mode pins come straight from registers
        s_d.pd = (s_d.st == pbm_pkg::PBM_PDOWN);
        s_d.scan = (s_d.st == pbm_pkg::PBM_NORMAL);
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            s_q <= RST_STATE;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = s_q.hrdata;
    assign ADC_START = s_q.adc_start;
    assign ADC_CHAN = s_q.chan;
    assign ADC_GAIN = s_q.gain;
    assign PACK_SHUTDOWN = s_q.pack_shutdown;
    assign POWER_DOWN = s_q.pd;
    assign POWER_FET_OFF = s_q.fet_off;
    assign SCAN_EN = s_q.scan;
    assign OW_SCAN_EN = s_q.ow_en;
    assign CB_OUT = s_q.cb;
    assign OP_MODE = s_q.st;

endmodule // pbm_ctrl

// *** tb/pbm_ctrl_assertions.sv ***
`timescale 1ns/1ps
module pbm_ctrl_assertions #(
    parameter int NCELL = 8
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // bus
    input wire logic HSEL,
    input wire logic HREADY,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HADDR,
    input wire logic [31:0] HWDATA,
    // pins
    input wire logic CHG_DET,
    input wire logic DSG_DET,
    input wire logic CELL_FAULT,
    input wire logic OPEN_WIRE,
    input wire logic SUPPLY_LOW,
    // outputs
    input wire logic ADC_START,
    input wire logic [3:0] ADC_CHAN,
    input wire logic [1:0] ADC_GAIN,
    input wire logic PACK_SHUTDOWN,
    input wire logic POWER_DOWN,
    input wire logic SCAN_EN,
    input wire logic OW_SCAN_EN,
    input wire logic [NCELL-1:0] CB_OUT,
    input wire logic [2:0] OP_MODE
);
    // options shadow rebuilt from bus writes, with two delayed copies
    logic aw_q;
    logic [6:0] opt_q, opt_p, opt_pp;
    wire logic wsel = HSEL && HREADY && HTRANS[1] && HWRITE;
    wire logic [3:0] wd_chan = HWDATA[3:0];
    wire logic [1:0] wd_gain = HWDATA[7:6];
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            aw_q <= 1'b0;
            opt_q <= 7'h00;
            opt_p <= 7'h00;
            opt_pp <= 7'h00;
        end else begin
            aw_q <= wsel && HADDR[7:0] == pbm_pkg::OFS_OPTIONS;
            opt_q <= aw_q ? HWDATA[6:0] : opt_q;
            opt_p <= opt_q;
            opt_pp <= opt_p;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence meas_wr;
        wsel && HADDR[7:0] == pbm_pkg::OFS_MEAS ##1 HWDATA[pbm_pkg::MEAS_START];
    endsequence
    start_launch_a: assert property (
        meas_wr |=> ADC_START && ADC_CHAN == $past(wd_chan) && ADC_GAIN == $past(wd_gain))
        else $error("conversion not launched as written");
    start_pulse_a: assert property (ADC_START |=> !ADC_START)
        else $error("start longer than one cycle");
    mode_decode_a: assert property (
        POWER_DOWN == (OP_MODE == 3'h4) && SCAN_EN == (OP_MODE == 3'h0))
        else $error("mode outputs disagree");
    pdown_hold_a: assert property (POWER_DOWN |=> POWER_DOWN)
        else $error("power down left");
    normal_return_a: assert property (
        OP_MODE == 3'h0 && $past(OP_MODE) != 3'h0 |-> $past(CHG_DET, 3) || $past(DSG_DET, 3))
        else $error("normal entered without current");
    cell_fault_flag_psd_a: assert property (
        $past(CELL_FAULT, 3) && opt_p[pbm_pkg::OPT_CELL_FAULT_FLAG_PSD] |-> PACK_SHUTDOWN)
        else $error("cell fault did not shut down");
    ow_psd_a: assert property (
        $past(OPEN_WIRE, 3) && opt_p[pbm_pkg::OPT_OW_PSD] |-> PACK_SHUTDOWN)
        else $error("open wire did not shut down");
    supply_low_lockout_pd_a: assert property (
        $past(SUPPLY_LOW, 3) && opt_p[pbm_pkg::OPT_SUPPLY_LOW_LOCKOUT_PD] |-> POWER_DOWN)
        else $error("supply low did not power down");
    ow_scan_a: assert property (opt_p[pbm_pkg::OPT_OW_SCAN_DIS] |-> !OW_SCAN_EN)
        else $error("open wire scan while disabled");
    bal_chg_a: assert property (
        CB_OUT != '0 && opt_pp[6:5] == pbm_pkg::BAL_CHARGE |-> $past(CHG_DET, 4))
        else $error("charge balance without charge");
    bal_dsg_a: assert property (
        CB_OUT != '0 && opt_pp[6:5] == pbm_pkg::BAL_DISCHARGE |-> $past(DSG_DET, 4))
        else $error("discharge balance without discharge");
endmodule // pbm_ctrl_assertions

bind pbm_ctrl pbm_ctrl_assertions #(.NCELL(NCELL)) u_chk (.*);

// *** tb/pbm_adc_model.sv ***
`timescale 1ns/1ps
module pbm_adc_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from the block
    input wire logic start,
    input wire logic [3:0] chan,
    input wire logic [1:0] gain,
    // answer delay, set by the bench
    input wire logic [3:0] lat,
    output logic done,
    output logic [13:0] data
);
    logic busy_q;
    logic [3:0] cnt_q;
    logic [13:0] code_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            code_q <= 14'h0000;
            done <= 1'b0;
            data <= 14'h0000;
        end else begin
            done <= 1'b0;
            // data churns outside done so a stale sample is caught
            data <= ~data;
            // channel and gain taken with the start
            if (start) begin
                busy_q <= 1'b1;
                cnt_q <= lat;
                code_q <= {chan, gain, 8'ha5};
            end else if (busy_q && cnt_q == 4'h0) begin
                busy_q <= 1'b0;
                done <= 1'b1;
                data <= code_q;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule // pbm_adc_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic SYS_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, CHG_DET, DSG_DET, CELL_FAULT;
    logic OPEN_WIRE, SUPPLY_LOW, ADC_START, ADC_DONE, PACK_SHUTDOWN, POWER_DOWN;
    logic POWER_FET_OFF, SCAN_EN, OW_SCAN_EN;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS, ADC_GAIN;
    logic [3:0] ADC_CHAN, lat;
    logic [13:0] ADC_DATA, TEMP1_CODE, TEMP2_CODE;
    logic [111:0] CELL_V;
    logic [7:0] CB_OUT;
    logic [2:0] OP_MODE;
    int n_mismatch, n_tests;
    pbm_ctrl dut (.CE(1'b1), .HSIZE(3'h2), .HREADY(HREADYOUT), .*);
    pbm_adc_model adc (.clk(SYS_CLK), .rst(RST), .start(ADC_START), .chan(ADC_CHAN),
        .gain(ADC_GAIN), .lat(lat), .done(ADC_DONE), .data(ADC_DATA));
    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        cyc(1);
        while (HREADYOUT !== 1'b1) cyc(1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        cyc(1);
        while (HREADYOUT !== 1'b1) cyc(1);
        rd = HRDATA;
        cyc(1);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    task automatic do_reset;
        {CHG_DET, DSG_DET, CELL_FAULT, OPEN_WIRE, SUPPLY_LOW} <= 5'h00;
        RST <= 1'b1;
        cyc(3);
        RST <= 1'b0;
        cyc(1);
    endtask
    task automatic t_regs;
        rchk("options", pbm_pkg::OFS_OPTIONS, 32'h0);
        rchk("delta", pbm_pkg::OFS_BAL_DELTA, 32'h10);
        rchk("eoc", pbm_pkg::OFS_EOC_THR, 32'h3fff);
        rchk("mode", pbm_pkg::OFS_MODE, 32'h0);
        bus(1'b1, 8'h40, 32'hffff);
        rchk("unmapped", 8'h40, 32'h0);
        $display("regs done");
    endtask
    task automatic t_meas;
        int n;
        for (int c = 0; c < 16; c++) begin
            lat <= c[0] ? 4'h1 : 4'h9;
            bus(1'b1, pbm_pkg::OFS_MEAS, {24'h0, c[1:0], 2'b01, c[3:0]});
            n = 0;
            do begin
                bus(1'b0, pbm_pkg::OFS_MEAS, 32'h0);
                n++;
            end while (rd[pbm_pkg::MEAS_BUSY] && n < 20);
            chk("chan", rd[3:0], c[3:0]);
            rchk("result", pbm_pkg::OFS_RESULT, {2'b10, c[3:0], c[1:0], 8'ha5});
        end
        $display("meas done");
    endtask
    task automatic t_modes;
        logic [2:0] v;
        for (int i = 1; i < 5; i++) begin
            v = (i == 4) ? 3'h1 : 3'(i);
            bus(1'b1, pbm_pkg::OFS_MODE, {29'h0, v});
            cyc(1);
            chk("op_mode", OP_MODE, v);
        end
        bus(1'b1, pbm_pkg::OFS_MODE, 32'h0);
        cyc(3);
        chk("none", OP_MODE, 3'h1);
        chk("scan off", SCAN_EN, 1'b0);
        CHG_DET <= 1'b1;
        cyc(5);
        chk("current", OP_MODE, 3'h0);
        chk("scan on", SCAN_EN, 1'b1);
        CHG_DET <= 1'b0;
        // current wins over a mode write until the synchroniser has drained
        cyc(3);
        bus(1'b1, pbm_pkg::OFS_MODE, 32'h4);
        DSG_DET <= 1'b1;
        cyc(5);
        chk("pdown", POWER_DOWN, 1'b1);
        chk("pdown mode", OP_MODE, 3'h4);
        do_reset();
        $display("modes done");
    endtask
    task automatic t_prot;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, pbm_pkg::OFS_OPTIONS, 32'h0);
            {OPEN_WIRE, CELL_FAULT} <= i ? 2'b10 : 2'b01;
            cyc(5);
            chk("psd off", PACK_SHUTDOWN, 1'b0);
            chk("ow scan", OW_SCAN_EN, !i);
            bus(1'b1, pbm_pkg::OFS_OPTIONS, i ? 32'h04 : 32'h12);
            cyc(4);
            chk("psd on", PACK_SHUTDOWN, 1'b1);
            chk("ow off", OW_SCAN_EN, 1'b0);
            bus(1'b1, pbm_pkg::OFS_STATUS, 32'h1);
            chk("psd held", PACK_SHUTDOWN, 1'b1);
            {OPEN_WIRE, CELL_FAULT} <= 2'b00;
            // a live fault blocks the clear, so let it leave the synchroniser
            cyc(3);
            bus(1'b1, pbm_pkg::OFS_STATUS, 32'h1);
            cyc(1);
            chk("psd clear", PACK_SHUTDOWN, 1'b0);
        end
        bus(1'b1, pbm_pkg::OFS_OPTIONS, 32'h0);
        SUPPLY_LOW <= 1'b1;
        cyc(5);
        chk("supply_low_lockout off", POWER_DOWN, 1'b0);
        bus(1'b1, pbm_pkg::OFS_OPTIONS, 32'h08);
        cyc(4);
        chk("supply_low_lockout on", POWER_DOWN, 1'b1);
        do_reset();
        $display("protection done");
    endtask
    task automatic cell0(input logic [13:0] v, input logic [7:0] e);
        CELL_V[13:0] <= v;
        cyc(6);
        chk("cb_out", CB_OUT, e);
    endtask
    task automatic t_bal;
        CELL_V <= {{6{14'h0e00}}, 14'h0e10, 14'h1011};
        for (int k = 0; k < 6; k++) begin
            bus(1'b1, pbm_pkg::OFS_OPTIONS, (k / 3) << 5);
            {DSG_DET, CHG_DET} <= 2'(k % 3);
            cyc(6);
            chk("cb_out", CB_OUT, (k % 3 == k / 3 + 1) ? 8'h01 : 8'h00);
        end
        {DSG_DET, CHG_DET} <= 2'b00;
        bus(1'b1, pbm_pkg::OFS_EOC_THR, 32'h1011);
        // host writes limits for the gain in use
        bus(1'b1, pbm_pkg::OFS_TEMP_LIM, 32'h100);
        bus(1'b1, pbm_pkg::OFS_TEMP_REC, 32'h200);
        TEMP2_CODE <= 14'h0050;
        bus(1'b1, pbm_pkg::OFS_OPTIONS, 32'h41);
        cyc(6);
        chk("fet off", POWER_FET_OFF, 1'b1);
        chk("cb fet", CB_OUT, 8'h01);
        bus(1'b1, pbm_pkg::OFS_OPTIONS, 32'h40);
        cyc(6);
        chk("cb hot", CB_OUT, 8'h00);
        TEMP2_CODE <= 14'h3000;
        cell0(14'h1011, 8'h01);
        chk("fet on", POWER_FET_OFF, 1'b0);
        cell0(14'h0f9d, 8'h01);
        cell0(14'h0f9c, 8'h00);
        cell0(14'h0f9d, 8'h00);
        $display("balance done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        n_mismatch++;
        finish_test();
    end
    initial begin
        {RST, HSEL, HWRITE, CHG_DET, DSG_DET, CELL_FAULT, OPEN_WIRE, SUPPLY_LOW} = 8'h80;
        {HADDR, HWDATA, HTRANS, lat} = '0;
        {TEMP1_CODE, TEMP2_CODE} = {14'h3000, 14'h3000};
        CELL_V = '0;
        do_reset();
        t_regs();
        t_meas();
        t_modes();
        t_prot();
        t_bal();
        finish_test();
    end
endmodule // testbench
